/* File: pfsr_pkg.sv */
// constants for the platform system register bank
package pfsr_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_ID     = 8'h00;
    localparam logic [7:0] OFS_SW     = 8'h04;
    localparam logic [7:0] OFS_LED    = 8'h08;
    localparam logic [7:0] OFS_C100   = 8'h24;
    localparam logic [7:0] OFS_FLAGS  = 8'h30;
    localparam logic [7:0] OFS_FCLR   = 8'h34;
    localparam logic [7:0] OFS_NVF    = 8'h38;
    localparam logic [7:0] OFS_NVCLR  = 8'h3C;
    localparam logic [7:0] OFS_CARD   = 8'h48;
    localparam logic [7:0] OFS_FLASH  = 8'h4C;
    localparam logic [7:0] OFS_BOOTSW = 8'h58;
    localparam logic [7:0] OFS_C24    = 8'h5C;
    localparam logic [7:0] OFS_MISC   = 8'h60;
    localparam logic [7:0] OFS_DMA    = 8'h64;
    localparam logic [7:0] OFS_PID0   = 8'h84;
    localparam logic [7:0] OFS_PID1   = 8'h88;
    localparam logic [7:0] OFS_PID2   = 8'h8C;
    localparam logic [7:0] OFS_PID3   = 8'h90;
    localparam logic [7:0] OFS_CDATA  = 8'hA0;
    localparam logic [7:0] OFS_CCTRL  = 8'hA4;
    localparam logic [7:0] OFS_CSTAT  = 8'hA8;

    // transfer control and status fields
    localparam int CTRL_START  = 31;
    localparam int CTRL_WRITE  = 30;
    localparam int CTRL_FN_LSB = 20;
    localparam int FN_W        = 6;
    localparam int SEL_W       = 12;
    localparam int STAT_DONE   = 0;
    localparam int STAT_ERR    = 1;
    localparam logic [FN_W-1:0] FN_SHUTDOWN = 6'h08;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // timing
    localparam int CLK_HZ   = 20_000_000;
    localparam int CLK_MHZ  = CLK_HZ / 1_000_000;
    localparam int SLOW_HZ  = 100;
    localparam int FAST_MHZ = 24;
    localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;

    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        CF_IDLE,
        CF_REQ,
        CF_DROP
    } pfsr_cf_t;

endpackage : pfsr_pkg

/* File: pfsr_regs.sv */
// platform system register bank with axi4-lite slave and config transfer port
`timescale 1ns/10ps

// Functional notes
// - switch register low byte returns the eight user switch positions
// - led register low byte drives the eight user leds, reads back
// - read-only counter at 0x24 increments at 100 Hz
// - read-only counter at 0x5C increments at 24 MHz
// - general flag register at 0x30 is readable and writable
// - write to 0x34 clears the selected general flag bits only
// - persistent flags at 0x38 survive the ordinary reset
// - write to 0x3C clears the selected persistent flag bits
// - data word at 0xA0 is sent on writes, filled on reads
// - software starts each transfer by writing control at 0xA4
// - status at 0xA8 reports transfer progress and outcome
// - boot-select switch register at 0x58 is readable and writable
// - four processor ident registers at 0x84 through 0x90
// - the shutdown function raises a platform shutdown request
module pfsr_regs #(
    parameter logic [31:0] ID_VALUE = 32'h0000_0001, // arbitrary value
    parameter int          SLOW_DIV_P = pfsr_pkg::SLOW_DIV,
    parameter int          CARD_W     = 2
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       por_n,
    input  wire logic [7:0]                 awaddr,
    input  wire logic                       awvalid,
    output      logic                       awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output      logic                       wready,
    output      logic [1:0]                 bresp,
    output      logic                       bvalid,
    input  wire logic                       bready,
    input  wire logic [7:0]                 araddr,
    input  wire logic                       arvalid,
    output      logic                       arready,
    output      logic [31:0]                rdata,
    output      logic [1:0]                 rresp,
    output      logic                       rvalid,
    input  wire logic                       rready,
    input  wire logic [7:0]                 user_switch_bank,
    output      logic [7:0]                 user_led,
    input  wire logic [CARD_W-1:0]          card_status,
    output      logic                       cfg_req,
    output      logic                       cfg_write,
    output      logic [pfsr_pkg::FN_W-1:0]  cfg_function,
    output      logic [pfsr_pkg::SEL_W-1:0] cfg_select,
    output      logic [31:0]                cfg_wdata,
    input  wire logic                       cfg_ack,
    input  wire logic                       cfg_err,
    input  wire logic [31:0]                cfg_rdata,
    output      logic                       platform_shutdown_request
);
    import pfsr_pkg::*;

    typedef struct packed {
        logic              aw_h;
        logic [7:0]        aw_a;
        logic              w_h;
        logic [31:0]       w_d;
        logic [3:0]        w_s;
        logic              bv;
        logic [1:0]        br;
        logic              rv;
        logic [31:0]       rd;
        logic [1:0]        rr;
        logic [31:0]       id;
        logic [31:0]       sw;
        logic [31:0]       led;
        logic [31:0]       flags;
        logic [31:0]       nvf;
        logic [31:0]       flash;
        logic [31:0]       bootsw;
        logic [31:0]       misc;
        logic [31:0]       dma;
        logic [3:0][31:0]  pid;
        logic [31:0]       cdata;
        logic [31:0]       cctrl;
        logic [31:0]       cstat;
        logic [31:0]       c100;
        logic [31:0]       c24;
        logic [31:0]       div;
        logic [5:0]        ph;
        pfsr_cf_t          cf;
        logic              shut;
        logic [7:0]        sw_m;
        logic [7:0]        sw_s;
        logic [CARD_W-1:0] card_m;
        logic [CARD_W-1:0] card_s;
        logic [1:0]        ack_m;
        logic [1:0]        ack_s;
        logic [31:0]       crd_m;
        logic [31:0]       crd_s;
    } pfsr_st_t;

    pfsr_st_t s;
    pfsr_st_t next_s;

    function automatic logic mapped(input logic [7:0] a);
        case (a)
            OFS_ID, OFS_SW, OFS_LED, OFS_C100, OFS_FLAGS, OFS_FCLR,
            OFS_NVF, OFS_NVCLR, OFS_CARD, OFS_FLASH, OFS_BOOTSW,
            OFS_C24, OFS_MISC, OFS_DMA, OFS_PID0, OFS_PID1, OFS_PID2,
            OFS_PID3, OFS_CDATA, OFS_CCTRL, OFS_CSTAT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    logic [31:0] wv;
    logic [6:0]  sum;
    logic        busy;
    logic [7:0]  ra;

    always_comb begin
        next_s = s;
        wv     = merge(RST_ZERO, s.w_d, s.w_s);
        busy   = (s.cf != CF_IDLE);
        ra     = {araddr[7:2], 2'h0};
        next_s.shut   = 1'b0;
        next_s.sw_m   = user_switch_bank;
        next_s.sw_s   = s.sw_m;
        next_s.card_m = card_status;
        next_s.card_s = s.card_m;
        next_s.ack_m  = {cfg_ack, cfg_err};
        next_s.ack_s  = s.ack_m;
        next_s.crd_m  = cfg_rdata;
        next_s.crd_s  = s.crd_m;

        // free-running time bases
        if (s.div >= 32'(SLOW_DIV_P - 1)) begin
            next_s.div  = RST_ZERO;
            next_s.c100 = s.c100 + 32'h0000_0001;
        end else begin
            next_s.div = s.div + 32'h0000_0001;
        end
        // 24 MHz is faster than the 20 MHz clock: a phase accumulator
        // adds one or two per cycle so the long-run rate is exact
        sum = 7'(s.ph) + 7'(FAST_MHZ);
        if (sum >= 7'(2 * CLK_MHZ)) begin
            next_s.c24 = s.c24 + 32'h0000_0002;
            next_s.ph  = 6'(sum - 7'(2 * CLK_MHZ));
        end else if (sum >= 7'(CLK_MHZ)) begin
            next_s.c24 = s.c24 + 32'h0000_0001;
            next_s.ph  = 6'(sum - 7'(CLK_MHZ));
        end else begin
            next_s.ph = 6'(sum);
        end

        // bus channel acceptance
        if (awvalid && awready) begin
            next_s.aw_h = 1'b1;
            next_s.aw_a = {awaddr[7:2], 2'h0};
        end
        if (wvalid && wready) begin
            next_s.w_h = 1'b1;
            next_s.w_d = wdata;
            next_s.w_s = wstrb;
        end
        if (s.bv && bready) begin
            next_s.bv = 1'b0;
        end
        if (s.rv && rready) begin
            next_s.rv = 1'b0;
        end

        if (arvalid && arready) begin
            next_s.rv = 1'b1;
            next_s.rr = mapped(ra) ? RESP_OKAY : RESP_DECERR;
            case (ra)
                OFS_ID:     next_s.rd = s.id;
                OFS_SW:     next_s.rd = {s.sw[31:8], s.sw_s};
                OFS_LED:    next_s.rd = s.led;
                OFS_C100:   next_s.rd = s.c100;
                OFS_FLAGS:  next_s.rd = s.flags;
                OFS_NVF:    next_s.rd = s.nvf;
                OFS_CARD:   next_s.rd = 32'(s.card_s);
                OFS_FLASH:  next_s.rd = s.flash;
                OFS_BOOTSW: next_s.rd = s.bootsw;
                OFS_C24:    next_s.rd = s.c24;
                OFS_MISC:   next_s.rd = s.misc;
                OFS_DMA:    next_s.rd = s.dma;
                OFS_PID0:   next_s.rd = s.pid[0];
                OFS_PID1:   next_s.rd = s.pid[1];
                OFS_PID2:   next_s.rd = s.pid[2];
                OFS_PID3:   next_s.rd = s.pid[3];
                OFS_CDATA:  next_s.rd = s.cdata;
                OFS_CCTRL:  next_s.rd = s.cctrl;
                OFS_CSTAT:  next_s.rd = s.cstat;
                default:    next_s.rd = RST_ZERO;
            endcase
        end

        // commit a write once both address and data are held
        if (s.aw_h && s.w_h && !s.bv) begin
            next_s.aw_h = 1'b0;
            next_s.w_h  = 1'b0;
            next_s.bv   = 1'b1;
            next_s.br   = mapped(s.aw_a) ? RESP_OKAY : RESP_DECERR;
            case (s.aw_a)
                OFS_ID:     next_s.id = merge(s.id, s.w_d, s.w_s);
                OFS_SW:     next_s.sw = merge(s.sw, s.w_d, s.w_s);
                OFS_LED:    next_s.led = merge(s.led, s.w_d, s.w_s);
                OFS_FLAGS:  next_s.flags = merge(s.flags, s.w_d, s.w_s);
                OFS_FCLR:   next_s.flags = s.flags & ~wv;
                OFS_NVF:    next_s.nvf = merge(s.nvf, s.w_d, s.w_s);
                OFS_NVCLR:  next_s.nvf = s.nvf & ~wv;
                OFS_FLASH:  next_s.flash = merge(s.flash, s.w_d, s.w_s);
                OFS_BOOTSW: next_s.bootsw = merge(s.bootsw, s.w_d, s.w_s);
                OFS_MISC:   next_s.misc = merge(s.misc, s.w_d, s.w_s);
                OFS_DMA:    next_s.dma = merge(s.dma, s.w_d, s.w_s);
                OFS_PID0:   next_s.pid[0] = merge(s.pid[0], s.w_d, s.w_s);
                OFS_PID1:   next_s.pid[1] = merge(s.pid[1], s.w_d, s.w_s);
                OFS_PID2:   next_s.pid[2] = merge(s.pid[2], s.w_d, s.w_s);
                OFS_PID3:   next_s.pid[3] = merge(s.pid[3], s.w_d, s.w_s);
                OFS_CDATA: begin
                    // frozen during a transfer so the outgoing word stays stable
                    if (!busy) begin
                        next_s.cdata = merge(s.cdata, s.w_d, s.w_s);
                    end
                end
                OFS_CCTRL: begin
                    if (!busy) begin
                        next_s.cctrl = merge(s.cctrl, s.w_d, s.w_s);
                    end
                end
                OFS_CSTAT:  next_s.cstat = merge(s.cstat, s.w_d, s.w_s);
                default: ; // read-only and unmapped: no side effect
            endcase
        end

        // transfer sequencer runs after the write so hardware status wins
        case (s.cf)
            CF_IDLE: begin
                if (s.cctrl[CTRL_START]) begin
                    next_s.cf = CF_REQ;
                    next_s.cstat[STAT_DONE] = 1'b0;
                    next_s.cstat[STAT_ERR]  = 1'b0;
                    if (s.cctrl[CTRL_FN_LSB +: FN_W] == FN_SHUTDOWN) begin
                        next_s.shut = 1'b1;
                    end
                end
            end
            CF_REQ: begin
                if (s.ack_s[1]) begin
                    next_s.cf = CF_DROP;
                    next_s.cstat[STAT_ERR] = s.ack_s[0];
                    if (!s.cctrl[CTRL_WRITE]) begin
                        next_s.cdata = s.crd_s;
                    end
                end
            end
            CF_DROP: begin
                if (!s.ack_s[1]) begin
                    next_s.cf = CF_IDLE;
                    next_s.cctrl[CTRL_START] = 1'b0;
                    next_s.cstat[STAT_DONE]  = 1'b1;
                end
            end
            default: next_s.cf = CF_IDLE;
        endcase
    end

    // por_n clears all state except id, which loads ID_VALUE; aresetn also keeps the persistent flags
    always_ff @(posedge aclk) begin
        if (!por_n || !aresetn) begin
            s      <= '0;
            s.id   <= ID_VALUE;
            s.cf   <= CF_IDLE;
            s.sw_m <= 8'h00;
            if (por_n) begin
                s.nvf <= s.nvf;
            end
        end else begin
            s <= next_s;
        end
    end

    assign awready = !s.aw_h && !s.bv;
    assign wready  = !s.w_h && !s.bv;
    assign bvalid  = s.bv;
    assign bresp   = s.br;
    assign arready = !s.rv;
    assign rvalid  = s.rv;
    assign rdata   = s.rd;
    assign rresp   = s.rr;
    assign user_led     = s.led[7:0];
    assign cfg_req      = (s.cf == CF_REQ);
    assign cfg_write    = s.cctrl[CTRL_WRITE];
    assign cfg_function = s.cctrl[CTRL_FN_LSB +: FN_W];
    assign cfg_select   = s.cctrl[SEL_W-1:0];
    assign cfg_wdata    = s.cdata;
    assign platform_shutdown_request = s.shut;

endmodule : pfsr_regs

/* File: pfsr_regs_asserts.sv */
// concurrent checks on the register bank ports
`timescale 1ns/10ps
module pfsr_regs_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        por_n,
    input wire logic        awready,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic        cfg_req,
    input wire logic        cfg_write,
    input wire logic [31:0] cfg_wdata,
    input wire logic        cfg_ack,
    input wire logic        platform_shutdown_request
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !por_n);
    ar_block_a: assert property (rvalid |-> !arready) else $error("arready high with read pending");
    read_lat_a: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer changed before taken");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer changed before taken");
    aw_block_a: assert property (bvalid |-> !awready && !wready) else $error("write taken with answer pending");
    sd_pulse_a: assert property (platform_shutdown_request |=> !platform_shutdown_request)
        else $error("shutdown request longer than one cycle");
    cfg_stable_a: assert property (cfg_req ##1 cfg_req |-> $stable(cfg_wdata) && $stable(cfg_write))
        else $error("transfer outputs moved during request");
    req_hold_a: assert property (cfg_req && !cfg_ack |=> cfg_req)
        else $error("request dropped before acknowledge");
    req_drop_a: assert property ($rose(cfg_ack) && cfg_req |-> ##[1:5] !cfg_req)
        else $error("request not dropped after acknowledge");
    rst_idle_a: assert property (disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && !cfg_req)
        else $error("outputs not idle after reset");
endmodule : pfsr_regs_chk

bind pfsr_regs pfsr_regs_chk u_chk (.*);

/* File: pfsr_cfg_partner.sv */
// behavioural configuration controller on the far side of the transfer port
`timescale 1ns/10ps
module pfsr_cfg_partner (
    input  wire logic        aclk,
    input  wire logic        cfg_req,
    input  wire logic [31:0] cfg_wdata,
    input  wire logic [3:0]  dly,
    input  wire logic        bad,
    input  wire logic [31:0] word,
    output      logic        cfg_ack,
    output      logic        cfg_err,
    output      logic [31:0] cfg_rdata,
    output      logic [31:0] got
);
    logic [3:0] n = 4'h0;
    initial begin
        cfg_ack = 1'b0;
        cfg_err = 1'b0;
        cfg_rdata = 32'h0000_0000;
        got = 32'h0000_0000;
    end
    always @(posedge aclk) begin
        // read data is not held outside a handshake, so it toggles every cycle
        if (!cfg_ack) cfg_rdata <= ~cfg_rdata;
        if (cfg_req == cfg_ack) n <= 4'h0;
        else if (n < dly) n <= n + 4'h1;
        else begin
            n <= 4'h0;
            cfg_ack <= cfg_req;
            if (cfg_req) begin
                got <= cfg_wdata;
                cfg_err <= bad;
                cfg_rdata <= word;
            end
        end
    end
endmodule : pfsr_cfg_partner

/* File: pfsr_regs_bench.sv */
// self-checking bench for the platform system register bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module pfsr_regs_bench;
    import pfsr_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} pfsr_row_t;
    logic aclk = 0, aresetn = 0, por_n = 0, bad = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, user_switch_bank = 0, user_led;
    logic [31:0] wdata = 0, word = 32'h2468_ACE0, rdata, cfg_wdata, cfg_rdata, got, rv, a, b, st;
    logic [3:0] wstrb = 4'hF, dly = 4'h2;
    logic [1:0] card_status = 2'b10, bresp, rresp, rs, bs;
    logic awready, wready, bvalid, arready, rvalid, cfg_req, cfg_write, cfg_ack, cfg_err;
    logic platform_shutdown_request;
    logic [5:0] cfg_function;
    logic [11:0] cfg_select;
    int n_fail = 0, tests_run = 0, cyc = 0, n_sd = 0, t;
    pfsr_row_t rows [12] = '{
        '{OFS_LED,    32'h0000_00A5, 32'h0000_00A5},
        '{OFS_FLAGS,  32'hF0F0_1234, 32'hF0F0_1234},
        '{OFS_NVF,    32'h0000_00FF, 32'h0000_00FF},
        '{OFS_BOOTSW, 32'h0000_0003, 32'h0000_0003},
        '{OFS_PID0,   32'h1111_0000, 32'h1111_0000},
        '{OFS_PID1,   32'h2222_0001, 32'h2222_0001},
        '{OFS_PID2,   32'h3333_0002, 32'h3333_0002},
        '{OFS_PID3,   32'h4444_0003, 32'h4444_0003},
        '{OFS_CDATA,  32'h0BAD_F00D, 32'h0BAD_F00D},
        '{OFS_FCLR,   32'h0000_0000, 32'h0000_0000},
        '{OFS_NVCLR,  32'h0000_0000, 32'h0000_0000},
        '{OFS_CARD,   32'hFFFF_FFFF, 32'h0000_0002}};
    pfsr_regs #(.SLOW_DIV_P(10)) u_pfsr_regs (.*);
    pfsr_cfg_partner u_pfsr_cfg_partner (.*);
    always #25 aclk = ~aclk;
    always @(posedge aclk) if (platform_shutdown_request === 1'b1) n_sd++;
    task give_verdict;
        if (n_fail == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    task wr(input logic [7:0] ad, input logic [31:0] d);
        awaddr <= ad; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        // bready stays high so a following call never reassigns it in the same step
        bs = bresp;
    endtask : wr
    task rd(input logic [7:0] ad);
        araddr <= ad; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        rv = rdata; rs = rresp;
    endtask : rd
    task xfer(input logic [31:0] ctl);
        wr(OFS_CCTRL, ctl);
        for (int i = 0; i < 60; i++) begin
            rd(OFS_CSTAT);
            if (rv[STAT_DONE] === 1'b1) break;
        end
        st = rv;
    endtask : xfer
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1; por_n <= 1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a);
            `CHK("readback", rows[i].e, rv);
        end
        `CHK("leds", 8'hA5, user_led);
        wr(OFS_FCLR, 32'h0000_0030); rd(OFS_FLAGS);
        `CHK("flag clear", 32'hF0F0_1204, rv);
        wr(OFS_NVCLR, 32'h0000_000F); rd(OFS_NVF);
        `CHK("nv clear", 32'h0000_00F0, rv);
        rd(OFS_C100); a = rv; t = cyc; rd(OFS_C24); b = rv;
        wr(OFS_C100, 32'h0000_0000); wr(OFS_C24, 32'h0000_0000);
        repeat (150) @(posedge aclk);
        rd(OFS_C100); a = rv - a; t = cyc - t; rd(OFS_C24); b = rv - b;
        `CHK("slow count", 1'b1, (a >= t / 10 - 1 && a <= t / 10 + 1));
        `CHK("fast count", 1'b1, (b >= t * 6 / 5 - 2 && b <= t * 6 / 5 + 2));
        rd(8'hFC); `CHK("unmapped rd", {RESP_DECERR, 32'h0000_0000}, {rs, rv});
        wr(8'hFC, 32'h0000_0001); `CHK("unmapped wr", RESP_DECERR, bs);
        wr(OFS_CDATA, 32'h1357_9BDF); xfer(32'hC010_0005);
        `CHK("wr status", 2'b01, st[1:0]);
        `CHK("sent word", 32'h1357_9BDF, got);
        `CHK("write dir", 1'b1, cfg_write);
        dly <= 4'h9; xfer(32'h8020_0005); rd(OFS_CDATA);
        `CHK("fetched word", 32'h2468_ACE0, rv);
        `CHK("select", 12'h005, cfg_select);
        rd(OFS_CCTRL); `CHK("start cleared", 32'h0020_0005, rv);
        `CHK("no shutdown", 0, n_sd);
        bad <= 1; dly <= 4'h0; xfer(32'h8080_0000);
        `CHK("err status", 2'b11, st[1:0]);
        `CHK("shutdown", 1, n_sd);
        `CHK("function", FN_SHUTDOWN, cfg_function);
        user_switch_bank <= 8'h5A; aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        repeat (3) @(posedge aclk);
        rd(OFS_SW); `CHK("switches", 32'h0000_005A, rv);
        rd(OFS_FLAGS); `CHK("flags reset", 32'h0000_0000, rv);
        rd(OFS_NVF); `CHK("nv kept", 32'h0000_00F0, rv);
        `CHK("leds reset", 8'h00, user_led);
        give_verdict();
    end
endmodule : pfsr_regs_bench
